/* hdl/dcsdc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - bit 4: open or close pages policy
// - bit 3 forces activate delay two clocks
// - bit 2: latency and delay two or three
// - bit 1: active/refresh times 5/8 or 7/10
// - bit 0: precharge two or three clocks
// - timing register resets to 17h
// - refresh field: 00 off, 01 normal
// - special code 000 is normal operation
// - code 001 turns cycles into nop
// - code 010 turns cycles into precharge-all
// - code 011 turns cycles into mode set
// - mode set drives upper lines 11:7 zero
// - code 100 turns cycles into refresh
// - command register resets to 08h
// - registers reached only at mapped offsets
module dcsdc_ctrl (
   input  wire logic                   clk_sys_in,
   input  wire logic                   nrst_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic [15:0]            reg_addr_in,
   input  wire logic [7:0]             reg_wdata_in,
   output logic      [7:0]             reg_rdata_out,
   input  wire dcsdc_pkg::dcsdc_req_s  req_in,
   output logic                        req_ready_out,
   output logic                        rd_valid_out,
   output dcsdc_pkg::dcsdc_mem_s       mem_out
);

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ACT_WAIT,
      ST_ACCESS,
      ST_LATENCY,
      ST_RAS_WAIT,
      ST_PRE_WAIT,
      ST_REF_WAIT,
      ST_SPECIAL_WAIT
   } dcsdc_state_e;

   typedef struct packed {
      dcsdc_state_e          st;
      logic [3:0]            cnt;
      logic [3:0]            ras_cnt;
      logic [11:0]           ref_cnt;
      logic                  ref_due;
      logic                  row_open;
      logic [1:0]            open_bank;
      logic [11:0]           open_row;
      dcsdc_pkg::dcsdc_req_s req;
      logic                  ready;
      logic                  rd_valid;
      dcsdc_pkg::dcsdc_mem_s mem;
   } dcsdc_ctrl_state_s;

   dcsdc_ctrl_state_s      s_q;
   dcsdc_ctrl_state_s      s_d;
   dcsdc_pkg::dcsdc_timing_s tm;
   logic                   ras_met;

   dcsdc_regs u_regs (
      .clk_sys_in    (clk_sys_in),
      .nrst_in       (nrst_in),
      .reg_wr_in     (reg_wr_in),
      .reg_rd_in     (reg_rd_in),
      .reg_addr_in   (reg_addr_in),
      .reg_wdata_in  (reg_wdata_in),
      .reg_rdata_out (reg_rdata_out),
      .timing_out    (tm)
   );

   assign ras_met = s_q.ras_cnt >= tm.active_time;

   // ***************************************************************
   // command sequencer
   // ***************************************************************
   always_comb begin
      s_d          = s_q;
      s_d.mem.cmd  = dcsdc_pkg::CMD_NOP;
      s_d.rd_valid = 1'b0;
      s_d.ready    = 1'b0;
      if (s_q.cnt != 4'h0) begin
         s_d.cnt = s_q.cnt - 4'h1;
      end
      if (s_q.row_open && s_q.ras_cnt != 4'hf) begin
         s_d.ras_cnt = s_q.ras_cnt + 4'h1;
      end
      unique case (s_q.st)
         ST_IDLE: begin
            if (s_q.ref_due) begin
               // all rows must be closed before auto refresh
               if (s_q.row_open) begin
                  if (ras_met) begin
                     s_d.mem.cmd = dcsdc_pkg::CMD_PRECHARGE;
                     s_d.mem.addr[dcsdc_pkg::ALL_BANKS_POS] = dcsdc_pkg::ADDR_ALL_BANKS_BIT;
                     s_d.row_open = 1'b0;
                     s_d.cnt = tm.precharge_time - 4'h1;
                     s_d.st = ST_PRE_WAIT;
                  end
               end else begin
                  s_d.mem.cmd = dcsdc_pkg::CMD_REFRESH;
                  s_d.ref_due = 1'b0;
                  s_d.cnt = tm.refresh_time - 4'h1;
                  s_d.st = ST_REF_WAIT;
               end
            end else if (req_in.valid && !s_q.ready) begin
               s_d.req = req_in;
               unique case (tm.special)
                  dcsdc_pkg::CODE_NORMAL: begin
                     if (s_q.row_open && s_q.open_bank == req_in.bank &&
                         s_q.open_row == req_in.row) begin
                        s_d.st = ST_ACCESS;
                     end else if (s_q.row_open) begin
                        if (ras_met) begin
                           s_d.mem.cmd = dcsdc_pkg::CMD_PRECHARGE;
                           s_d.mem.addr[dcsdc_pkg::ALL_BANKS_POS] =
                              dcsdc_pkg::ADDR_ALL_BANKS_BIT;
                           s_d.row_open = 1'b0;
                           s_d.cnt = tm.precharge_time - 4'h1;
                           s_d.st = ST_PRE_WAIT;
                        end
                     end else begin
                        s_d.mem.cmd  = dcsdc_pkg::CMD_ACTIVE;
                        s_d.mem.bank = req_in.bank;
                        s_d.mem.addr = req_in.row;
                        s_d.row_open = 1'b1;
                        s_d.ras_cnt  = 4'h1;
                        s_d.open_bank = req_in.bank;
                        s_d.open_row = req_in.row;
                        s_d.cnt = tm.act_delay - 4'h1;
                        s_d.st = ST_ACT_WAIT;
                     end
                  end
                  dcsdc_pkg::CODE_NOP: begin
                     s_d.mem.cmd = dcsdc_pkg::CMD_NOP;
                     s_d.ready = 1'b1;
                  end
                  dcsdc_pkg::CODE_PRECHARGE: begin
                     s_d.mem.cmd = dcsdc_pkg::CMD_PRECHARGE;
                     s_d.mem.addr[dcsdc_pkg::ALL_BANKS_POS] = dcsdc_pkg::ADDR_ALL_BANKS_BIT;
                     s_d.row_open = 1'b0;
                     s_d.cnt = tm.precharge_time - 4'h1;
                     s_d.st = ST_SPECIAL_WAIT;
                  end
                  dcsdc_pkg::CODE_MODE_SET: begin
                     s_d.mem.cmd  = dcsdc_pkg::CMD_MODE_SET;
                     s_d.mem.bank = 2'h0;
                     // mode value rides on the low seven column lines
                     s_d.mem.addr = {5'h00, req_in.col[6:0]};
                     s_d.cnt = tm.precharge_time - 4'h1;
                     s_d.st = ST_SPECIAL_WAIT;
                  end
                  dcsdc_pkg::CODE_REFRESH: begin
                     s_d.mem.cmd = dcsdc_pkg::CMD_REFRESH;
                     s_d.cnt = tm.refresh_time - 4'h1;
                     s_d.st = ST_SPECIAL_WAIT;
                  end
                  default: begin
                     // reserved codes complete the cycle without a command
                     s_d.ready = 1'b1;
                  end
               endcase
            end
         end
         ST_ACT_WAIT: begin
            if (s_q.cnt <= 4'h1) begin
               s_d.st = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            s_d.mem.bank = s_q.req.bank;
            s_d.mem.addr = s_q.req.col;
            if (s_q.req.write) begin
               s_d.mem.cmd = dcsdc_pkg::CMD_WRITE;
               s_d.ready = 1'b1;
               s_d.st = ST_RAS_WAIT;
            end else begin
               s_d.mem.cmd = dcsdc_pkg::CMD_READ;
               s_d.cnt = tm.cas_latency - 4'h1;
               s_d.st = ST_LATENCY;
            end
         end
         ST_LATENCY: begin
            if (s_q.cnt == 4'h0) begin
               s_d.rd_valid = 1'b1;
               s_d.ready = 1'b1;
               s_d.st = ST_RAS_WAIT;
            end
         end
         ST_RAS_WAIT: begin
            // page close policy shuts the row once active time is met
            if (!tm.close_pages) begin
               s_d.st = ST_IDLE;
            end else if (ras_met) begin
               s_d.mem.cmd = dcsdc_pkg::CMD_PRECHARGE;
               s_d.mem.addr[dcsdc_pkg::ALL_BANKS_POS] = dcsdc_pkg::ADDR_ALL_BANKS_BIT;
               s_d.row_open = 1'b0;
               s_d.cnt = tm.precharge_time - 4'h1;
               s_d.st = ST_PRE_WAIT;
            end
         end
         ST_PRE_WAIT, ST_REF_WAIT: begin
            if (s_q.cnt == 4'h0) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_SPECIAL_WAIT: begin
            if (s_q.cnt == 4'h0) begin
               s_d.ready = 1'b1;
               s_d.st = ST_IDLE;
            end
         end
      endcase
      // interval counter keeps running while refresh is off but raises nothing
      // it sits after the sequencer so a new due flag beats a same-cycle clear
      if (s_q.ref_cnt == 12'h000) begin
         s_d.ref_cnt = dcsdc_pkg::REFRESH_CYCLES;
         if (tm.refresh_on) begin
            s_d.ref_due = 1'b1;
         end
      end else begin
         s_d.ref_cnt = s_q.ref_cnt - 12'h001;
      end
      if (!tm.refresh_on) begin
         s_d.ref_due = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q.st        <= ST_IDLE;
         s_q.cnt       <= 4'h0;
         s_q.ras_cnt   <= 4'h0;
         s_q.ref_cnt   <= 12'h000;
         s_q.ref_due   <= 1'b0;
         s_q.row_open  <= 1'b0;
         s_q.open_bank <= 2'h0;
         s_q.open_row  <= 12'h000;
         s_q.req       <= '0;
         s_q.ready     <= 1'b0;
         s_q.rd_valid  <= 1'b0;
         s_q.mem       <= {dcsdc_pkg::CMD_NOP, 2'h0, 12'h000};
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready_out = s_q.ready;
   assign rd_valid_out  = s_q.rd_valid;
   assign mem_out       = s_q.mem;

endmodule

/* hdl/dcsdc_regs.sv */
`timescale 1ns/1ps
module dcsdc_regs (
   input  wire logic                   clk_sys_in,
   input  wire logic                   nrst_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic [15:0]            reg_addr_in,
   input  wire logic [7:0]             reg_wdata_in,
   output logic      [7:0]             reg_rdata_out,
   output dcsdc_pkg::dcsdc_timing_s    timing_out
);

   typedef struct packed {
      logic [7:0] timing;
      logic [7:0] refresh;
      logic [7:0] rdata;
   } dcsdc_regs_state_s;

   dcsdc_regs_state_s state_q;
   dcsdc_regs_state_s state_d;

   // ***************************************************************
   // memory-mapped registers
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      if (reg_wr_in && reg_addr_in == dcsdc_pkg::TIMING_REG_OFFSET) begin
         state_d.timing = reg_wdata_in & dcsdc_pkg::TIMING_REG_MASK;
      end
      if (reg_wr_in && reg_addr_in == dcsdc_pkg::REFRESH_REG_OFFSET) begin
         state_d.refresh = reg_wdata_in & dcsdc_pkg::REFRESH_REG_MASK;
      end
      if (reg_rd_in) begin
         // unmapped offsets read zero
         unique case (reg_addr_in)
            dcsdc_pkg::TIMING_REG_OFFSET:  state_d.rdata = state_q.timing;
            dcsdc_pkg::REFRESH_REG_OFFSET: state_d.rdata = state_q.refresh;
            default:                       state_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q.timing  <= dcsdc_pkg::TIMING_REG_RESET;
         state_q.refresh <= dcsdc_pkg::REFRESH_REG_RESET;
         state_q.rdata   <= 8'h00;
      end else begin
         state_q <= state_d;
      end
   end

   assign reg_rdata_out = state_q.rdata;

   // ***************************************************************
   // decode of timing fields
   // ***************************************************************
   always_comb begin
      timing_out.close_pages = state_q.timing[dcsdc_pkg::PAGING_POLICY_BIT];
      timing_out.cas_latency = state_q.timing[dcsdc_pkg::CAS_LATENCY_BIT] ?
                               dcsdc_pkg::CL_LONG : dcsdc_pkg::CL_SHORT;
      if (state_q.timing[dcsdc_pkg::ACT_OVERRIDE_BIT]) begin
         timing_out.act_delay = dcsdc_pkg::RCD_OVERRIDE;
      end else begin
         timing_out.act_delay = timing_out.cas_latency;
      end
      timing_out.active_time = state_q.timing[dcsdc_pkg::ACTIVE_TIME_BIT] ?
                               dcsdc_pkg::TRAS_LONG : dcsdc_pkg::TRAS_SHORT;
      timing_out.refresh_time = state_q.timing[dcsdc_pkg::ACTIVE_TIME_BIT] ?
                                dcsdc_pkg::TRC_LONG : dcsdc_pkg::TRC_SHORT;
      timing_out.precharge_time = state_q.timing[dcsdc_pkg::PRECHARGE_TIME_BIT] ?
                                  dcsdc_pkg::TRP_LONG : dcsdc_pkg::TRP_SHORT;
      // reserved refresh codes behave as refresh off
      timing_out.refresh_on = state_q.refresh[dcsdc_pkg::REFRESH_FIELD_LSB +: 2] ==
                              dcsdc_pkg::REFRESH_NORMAL;
      timing_out.special = state_q.refresh[dcsdc_pkg::SPECIAL_FIELD_LSB +: 3];
   end

endmodule

/* pkg/dcsdc_pkg.sv */
package dcsdc_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [15:0] TIMING_REG_OFFSET  = 16'h3001;
   localparam logic [15:0] REFRESH_REG_OFFSET = 16'h3002;
   localparam logic [7:0]  TIMING_REG_RESET   = 8'h17;
   localparam logic [7:0]  REFRESH_REG_RESET  = 8'h08;
   localparam logic [7:0]  TIMING_REG_MASK    = 8'h1f;
   localparam logic [7:0]  REFRESH_REG_MASK   = 8'h1f;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int PAGING_POLICY_BIT   = 4;
   localparam int ACT_OVERRIDE_BIT    = 3;
   localparam int CAS_LATENCY_BIT     = 2;
   localparam int ACTIVE_TIME_BIT     = 1;
   localparam int PRECHARGE_TIME_BIT  = 0;
   localparam int REFRESH_FIELD_LSB   = 3;
   localparam int SPECIAL_FIELD_LSB   = 0;

   localparam logic [1:0] REFRESH_OFF    = 2'h0;
   localparam logic [1:0] REFRESH_NORMAL = 2'h1;

   // special command codes
   localparam logic [2:0] CODE_NORMAL    = 3'h0;
   localparam logic [2:0] CODE_NOP       = 3'h1;
   localparam logic [2:0] CODE_PRECHARGE = 3'h2;
   localparam logic [2:0] CODE_MODE_SET  = 3'h3;
   localparam logic [2:0] CODE_REFRESH   = 3'h4;

   // ***************************************************************
   // timing counts in memory clocks
   // ***************************************************************
   localparam logic [3:0] CL_SHORT      = 4'h2;
   localparam logic [3:0] CL_LONG       = 4'h3;
   localparam logic [3:0] RCD_OVERRIDE  = 4'h2;
   localparam logic [3:0] TRAS_SHORT    = 4'h5;
   localparam logic [3:0] TRAS_LONG     = 4'h7;
   localparam logic [3:0] TRC_SHORT     = 4'h8;
   localparam logic [3:0] TRC_LONG      = 4'ha;
   localparam logic [3:0] TRP_SHORT     = 4'h2;
   localparam logic [3:0] TRP_LONG      = 4'h3;
   // refresh interval: 15.6 us at 20 MHz
   localparam int         REFRESH_NS         = 15600;
   localparam int         CLK_PERIOD_NS      = 50;
   localparam int         REFRESH_CYCLES_INT = REFRESH_NS / CLK_PERIOD_NS;
   localparam logic [11:0] REFRESH_CYCLES    = 12'(REFRESH_CYCLES_INT);

   // ***************************************************************
   // sdram command encoding {cs_n, ras_n, cas_n, we_n}
   // ***************************************************************
   localparam logic [3:0] CMD_NOP       = 4'h7;
   localparam logic [3:0] CMD_ACTIVE    = 4'h3;
   localparam logic [3:0] CMD_READ      = 4'h5;
   localparam logic [3:0] CMD_WRITE     = 4'h4;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH   = 4'h1;
   localparam logic [3:0] CMD_MODE_SET  = 4'h0;
   localparam logic       ADDR_ALL_BANKS_BIT = 1'b1;
   localparam int         ALL_BANKS_POS = 10;

   typedef struct packed {
      logic [3:0] cas_latency;
      logic [3:0] act_delay;
      logic [3:0] active_time;
      logic [3:0] refresh_time;
      logic [3:0] precharge_time;
      logic       close_pages;
      logic       refresh_on;
      logic [2:0] special;
   } dcsdc_timing_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  bank;
      logic [11:0] row;
      logic [11:0] col;
   } dcsdc_req_s;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [1:0]  bank;
      logic [11:0] addr;
   } dcsdc_mem_s;

endpackage

/* tb/dcsdc_ctrl_sva.sv */
`timescale 1ns/1ps
// ***************************************************************
// port checker
// ***************************************************************
module dcsdc_ctrl_sva (
   input wire logic                  clk_sys_in,
   input wire logic                  nrst_in,
   input wire logic                  reg_wr_in,
   input wire logic                  reg_rd_in,
   input wire logic [15:0]           reg_addr_in,
   input wire logic [7:0]            reg_wdata_in,
   input wire logic [7:0]            reg_rdata_out,
   input wire dcsdc_pkg::dcsdc_req_s req_in,
   input wire logic                  req_ready_out,
   input wire logic                  rd_valid_out,
   input wire dcsdc_pkg::dcsdc_mem_s mem_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   logic [3:0] cmd;
   logic       mapped;
   assign cmd = mem_out.cmd;
   assign mapped = (reg_addr_in == dcsdc_pkg::TIMING_REG_OFFSET)
                || (reg_addr_in == dcsdc_pkg::REFRESH_REG_OFFSET);

   sequence s_act;
      cmd == dcsdc_pkg::CMD_ACTIVE;
   endsequence
   sequence s_col;
      cmd == dcsdc_pkg::CMD_READ || cmd == dcsdc_pkg::CMD_WRITE;
   endsequence

   property p_ready_pulse; req_ready_out |=> !req_ready_out; endproperty
   property p_ready_req; req_ready_out |-> req_in.valid; endproperty
   property p_rdv_ready; rd_valid_out |-> req_ready_out; endproperty
   property p_act_col; s_act |-> ##[2:3] s_col; endproperty
   property p_cas; cmd == dcsdc_pkg::CMD_READ |-> ##[2:3] rd_valid_out; endproperty
   property p_mode_hi;
      cmd == dcsdc_pkg::CMD_MODE_SET |-> mem_out.addr[11:7] == 5'h00;
   endproperty
   property p_mode_val;
      cmd == dcsdc_pkg::CMD_MODE_SET |-> mem_out.addr[6:0] == req_in.col[6:0];
   endproperty
   // earliest activate after refresh is eight clocks on
   property p_ref_gap;
      cmd == dcsdc_pkg::CMD_REFRESH |=> (cmd != dcsdc_pkg::CMD_ACTIVE)[*7];
   endproperty
   property p_ras; s_act |=> (cmd != dcsdc_pkg::CMD_PRECHARGE)[*4]; endproperty
   property p_pre_all;
      cmd == dcsdc_pkg::CMD_PRECHARGE |-> mem_out.addr[dcsdc_pkg::ALL_BANKS_POS] == 1'b1;
   endproperty
   property p_unmapped; reg_rd_in && !mapped |=> reg_rdata_out == 8'h00; endproperty
   property p_resv; reg_rd_in && mapped |=> reg_rdata_out[7:5] == 3'h0; endproperty

   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   a_ready_req: assert property (p_ready_req)
      else $error("ready without request");
   a_rdv_ready: assert property (p_rdv_ready)
      else $error("read valid apart from ready");
   a_act_col: assert property (p_act_col)
      else $error("activate not followed by column command");
   a_cas: assert property (p_cas)
      else $error("read data late");
   a_mode_hi: assert property (p_mode_hi)
      else $error("mode set upper lines not zero");
   a_mode_val: assert property (p_mode_val)
      else $error("mode set value wrong");
   a_ref_gap: assert property (p_ref_gap)
      else $error("activate too soon after refresh");
   a_ras: assert property (p_ras)
      else $error("precharge too soon after activate");
   a_pre_all: assert property (p_pre_all)
      else $error("precharge not to all banks");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_resv: assert property (p_resv)
      else $error("reserved bits not zero");
endmodule

bind dcsdc_ctrl dcsdc_ctrl_sva dcsdc_ctrl_sva_i (.clk_sys_in, .nrst_in, .reg_wr_in,
   .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .req_in, .req_ready_out,
   .rd_valid_out, .mem_out);

/* tb/dcsdc_ctrl_test.sv */
`timescale 1ns/1ps
module dcsdc_ctrl_test;
   localparam logic [15:0] TR = dcsdc_pkg::TIMING_REG_OFFSET;
   localparam logic [15:0] RR = dcsdc_pkg::REFRESH_REG_OFFSET;
   localparam int ACT = dcsdc_pkg::CMD_ACTIVE;
   localparam int RD  = dcsdc_pkg::CMD_READ;
   localparam int PR  = dcsdc_pkg::CMD_PRECHARGE;
   localparam int MS  = dcsdc_pkg::CMD_MODE_SET;
   localparam int RF  = dcsdc_pkg::CMD_REFRESH;
   localparam int WR  = dcsdc_pkg::CMD_WRITE;
   logic                  clk_sys_in   = 1'b0;
   logic                  nrst_in      = 1'b0;
   logic                  reg_wr_in    = 1'b0;
   logic                  reg_rd_in    = 1'b0;
   logic [15:0]           reg_addr_in  = 16'h0000;
   logic [7:0]            reg_wdata_in = 8'h00;
   logic [7:0]            reg_rdata_out;
   dcsdc_pkg::dcsdc_req_s req_in       = '0;
   logic                  req_ready_out;
   logic                  rd_valid_out;
   dcsdc_pkg::dcsdc_mem_s mem_out;
   int                    num_errors   = 0;
   int                    check_count  = 0;
   int unsigned           t_rdy;
   logic                  rdv_seen;
   logic [7:0]            rv;
   logic                  req_wr       = 1'b0;

   dcsdc_ctrl dcsdc_ctrl_i (.clk_sys_in, .nrst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
      .reg_wdata_in, .reg_rdata_out, .req_in, .req_ready_out, .rd_valid_out, .mem_out);
   dcsdc_sdram_model mdl (.clk_sys_in, .mem_in(mem_out));

   initial begin
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic gap(input int unsigned t0, input int unsigned t1, input int e);
      chk(16'(t1 - t0), 16'(e));
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(posedge clk_sys_in);
      d = reg_rdata_out;
   endtask
   // request held until ready is sampled, dropped at that same edge
   task automatic mem_req(input logic [11:0] row, input logic [11:0] col);
      int i;
      @(posedge clk_sys_in);
      req_in <= '{valid: 1'b1, write: req_wr, bank: 2'h1, row: row, col: col};
      for (i = 0; i < 400; i++) begin
         @(posedge clk_sys_in);
         if (req_ready_out === 1'b1) break;
      end
      if (i == 400) begin
         num_errors++;
         final_report();
      end
      t_rdy = mdl.cyc;
      rdv_seen = rd_valid_out;
      req_in <= '0;
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_regs();
      reg_rd(TR, rv);
      chk(16'(rv), 16'h0017);
      reg_rd(RR, rv);
      chk(16'(rv), 16'h0008);
      reg_rd(16'h3000, rv);
      chk(16'(rv), 16'h0000);
      reg_wr(TR, 8'hff);
      reg_wr(16'h3003, 8'h00);
      reg_rd(TR, rv);
      chk(16'(rv), 16'h001f);
   endtask
   // refresh stays off so the gaps are not stretched by refresh
   task automatic t_special();
      logic [7:0] tv;
      int unsigned n0;
      logic [11:0] mode_col;
      mode_col = 12'h5a5;
      for (int k = 0; k < 2; k++) begin
         tv = (k == 0) ? 8'h17 : 8'h14;
         reg_wr(TR, tv);
         for (int c = 1; c <= 5; c++) begin
            reg_wr(RR, {5'h00, 3'(c)});
            n0 = mdl.n_cmd;
            mem_req(12'h000, mode_col);
            case (c)
               2: begin
                  gap(mdl.t_of[PR], t_rdy, tv[0] ? 3 : 2);
                  chk(16'(mdl.addr_of[PR][10]), 16'h0001);
               end
               3: begin
                  gap(mdl.t_of[MS], t_rdy, tv[0] ? 3 : 2);
                  chk(16'(mdl.addr_of[MS]), 16'h0025);
               end
               4: gap(mdl.t_of[RF], t_rdy, tv[1] ? 10 : 8);
               default: chk(16'(mdl.n_cmd - n0), 16'h0000);
            endcase
         end
      end
      reg_wr(RR, 8'h00);
   endtask
   task automatic t_read();
      logic [7:0] tvs [4];
      tvs = '{8'h17, 8'h13, 8'h1c, 8'h1b};
      foreach (tvs[k]) begin
         reg_wr(TR, tvs[k]);
         mem_req(12'h010, 12'h004);
         gap(mdl.t_of[ACT], mdl.t_of[RD], tvs[k][3] ? 2 : (tvs[k][2] ? 3 : 2));
         gap(mdl.t_of[RD], t_rdy, tvs[k][2] ? 3 : 2);
         chk(16'(rdv_seen), 16'h0001);
      end
   endtask
   task automatic t_page();
      int unsigned a0;
      reg_wr(TR, 8'h13);
      a0 = mdl.cnt[ACT];
      mem_req(12'h020, 12'h000);
      mem_req(12'h020, 12'h008);
      gap(a0, mdl.cnt[ACT], 2);
      reg_wr(TR, 8'h03);
      a0 = mdl.cnt[ACT];
      req_wr = 1'b1;
      mem_req(12'h020, 12'h000);
      req_wr = 1'b0;
      // write command and ready share an edge, so let the model log it first
      @(posedge clk_sys_in);
      gap(mdl.t_of[ACT], mdl.t_of[WR], 2);
      chk(16'(rdv_seen), 16'h0000);
      mem_req(12'h020, 12'h008);
      gap(a0, mdl.cnt[ACT], 1);
   endtask
   task automatic t_refresh();
      int unsigned r0;
      r0 = mdl.cnt[RF];
      repeat (700) @(posedge clk_sys_in);
      gap(r0, mdl.cnt[RF], 0);
      reg_wr(RR, 8'h08);
      r0 = mdl.cnt[RF];
      for (int i = 0; i < 700 && mdl.cnt[RF] == r0; i++) begin
         @(posedge clk_sys_in);
      end
      gap(r0, mdl.cnt[RF], 1);
   endtask

   initial begin
      repeat (20) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_regs();
      t_special();
      t_read();
      t_page();
      t_refresh();
      final_report();
   end
endmodule

/* tb/dcsdc_sdram_model.sv */
`timescale 1ns/1ps
// ***************************************************************
// sdram side: passive, logs each non-nop command with its cycle
// ***************************************************************
module dcsdc_sdram_model (
   input wire logic                  clk_sys_in,
   input wire dcsdc_pkg::dcsdc_mem_s mem_in
);
   int unsigned cyc = 0;
   int unsigned n_cmd = 0;
   int unsigned t_of [16];
   int unsigned cnt [16];
   logic [11:0] addr_of [16];

   // an unknown command is not logged, so the bench sees it as missing
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (!$isunknown(mem_in.cmd) && mem_in.cmd != dcsdc_pkg::CMD_NOP) begin
         t_of[mem_in.cmd] <= cyc;
         cnt[mem_in.cmd] <= cnt[mem_in.cmd] + 1;
         addr_of[mem_in.cmd] <= mem_in.addr;
         n_cmd <= n_cmd + 1;
      end
   end
endmodule
